// [hw/three_wire_serial_control_port.sv]
// three-wire serial control port: command decode, checksum, transmit start
`timescale 1ns/1ns
module three_wire_serial_control_port
  import serial_port_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = HOLD_TIMEOUT // shorten in simulation
) (
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  input wire logic EN_I,
  input wire logic SCK_I,
  input wire logic SDIO_I,
  output logic SDIO_O,
  output logic SDIO_OE_O,
  output logic WR_VALID_O,
  output logic [5:0] WR_ADDR_O,
  output logic [7:0] WR_DATA_O,
  input wire logic WR_READY_I,
  output logic WR_OVERRUN_O,
  output logic [5:0] RD_ADDR_O,
  input wire logic [7:0] RD_DATA_I,
  output logic TX_START_O,
  output logic TX_SYNC_O,
  output logic TX_PA_MODE_O,
  output logic TX_ENCODE_O,
  output logic TX_POWER_SET_O,
  output logic [1:0] TX_CHANNEL_O,
  output logic TX_DATA_O,
  input wire logic BIT_TICK_I,
  output logic PA_ON_O,
  output logic SYNTH_ON_O
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] en_sync; // select: two stages plus edge history
  logic [2:0] sck_sync; // serial clock likewise
  logic [1:0] sdio_sync; // data line, two stages

  // first stage feeds only the second stage
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      en_sync <= 3'h0;
      sck_sync <= 3'h0;
      sdio_sync <= 2'h0;
    end else begin
      en_sync <= {en_sync[1:0], EN_I};
      sck_sync <= {sck_sync[1:0], SCK_I};
      sdio_sync <= {sdio_sync[0], SDIO_I};
    end
  end

  logic en_s, sck_s, sdio_s; // synchronised levels
  logic en_rise, en_fall, sck_rise, sck_fall; // edge strobes
  assign en_s = en_sync[1];
  assign sck_s = sck_sync[1];
  assign sdio_s = sdio_sync[1];
  assign en_rise = en_sync[1] & ~en_sync[2];
  assign en_fall = ~en_sync[1] & en_sync[2];
  assign sck_rise = sck_sync[1] & ~sck_sync[2];
  assign sck_fall = ~sck_sync[1] & sck_sync[2];

  // ----------------------------------------------------------------
  // serial engine
  // ----------------------------------------------------------------
  serial_state_type state, next_state; // command phase
  logic sample_rise, next_sample_rise; // captured edge polarity
  logic [2:0] bits, next_bits; // bits of current byte
  logic [7:0] shift, next_shift; // incoming shift register
  logic [5:0] addr, next_addr; // register address pointer
  logic [7:0] checksum, next_checksum; // write xor accumulator
  logic [3:0] out_cnt, next_out_cnt; // read bits launched
  logic sdio_o, next_sdio_o; // outgoing data bit
  logic sdio_oe, next_sdio_oe; // data line drive enable
  tx_cmd_type tx_cmd, next_tx_cmd; // latched transmit fields
  logic tx_start, next_tx_start; // transmit start pulse
  logic tx_data, next_tx_data; // datagram level to modulator
  logic samp, launch; // active sampling and output edges
  logic byte_done; // eighth bit sampled this cycle
  logic [7:0] in_byte; // completed byte, msb first
  logic [7:0] rd_byte; // value presented on a read
  logic push; // write word offered to buffer
  logic buf_ready; // buffer can take a word

  assign samp = sample_rise ? sck_rise : sck_fall;
  assign launch = sample_rise ? sck_fall : sck_rise;
  assign in_byte = {shift[6:0], sdio_s};
  assign byte_done = en_s && samp && bits == LAST_BIT &&
                     (state == ST_CMD || state == ST_WRITE);
  assign rd_byte = (addr == WRITE_XOR_CHECKSUM_ADDR) ? checksum : RD_DATA_I;

  // next values of the serial engine
  always_comb begin
    next_state = state;
    next_sample_rise = sample_rise;
    next_bits = bits;
    next_shift = shift;
    next_addr = addr;
    next_checksum = checksum;
    next_out_cnt = out_cnt;
    next_sdio_o = sdio_o;
    next_sdio_oe = sdio_oe;
    next_tx_cmd = tx_cmd;
    next_tx_start = 1'b0;
    next_tx_data = tx_data;
    push = 1'b0;
    if (en_rise) begin
      // new command: capture edge polarity from clock level
      next_sample_rise = sck_s;
      next_state = ST_CMD;
      next_bits = 3'h0;
      next_sdio_oe = 1'b0;
    end else if (en_fall) begin
      // command ends; release the line
      next_state = ST_IDLE;
      next_sdio_oe = 1'b0;
      if (state == ST_TX) begin
        next_tx_data = sdio_s;
      end
    end else if (en_s) begin
      if (samp && (state == ST_CMD || state == ST_WRITE)) begin
        // shift in msb first
        next_shift = in_byte;
        next_bits = bits + 3'h1;
      end
      if (byte_done && state == ST_CMD) begin
        // decode the command byte
        next_addr = in_byte[ADDR_HI:0];
        case (in_byte[FUNC_HI:FUNC_LO])
          FUNC_WRITE: begin
            next_checksum = checksum ^ in_byte;
            next_state = ST_WRITE;
          end
          FUNC_READ: begin
            next_out_cnt = 4'h0;
            next_state = ST_READ;
          end
          FUNC_TX: begin
            next_tx_cmd.sync = in_byte[TX_SYNC_BIT];
            next_tx_cmd.pa_mode = in_byte[TX_PAMODE_BIT];
            next_tx_cmd.encode = in_byte[TX_ENC_BIT];
            next_tx_cmd.power_set = in_byte[TX_PWR_BIT];
            next_tx_cmd.channel = in_byte[TX_CHAN_HI:0];
            next_tx_start = 1'b1;
            next_state = ST_TX;
          end
          default: begin
            // reserved code: rest of frame ignored
            next_state = ST_IDLE;
          end
        endcase
      end else if (byte_done) begin
        // data byte of a single or burst write
        next_checksum = checksum ^ in_byte;
        push = 1'b1;
        next_addr = addr + 6'h1;
      end
      if (state == ST_TX && samp) begin
        // datagram bits pass straight to the modulator
        next_tx_data = sdio_s;
      end
      if (state == ST_READ && launch) begin
        if (out_cnt < OUT_DONE) begin
          // drive one bit of the addressed register
          next_sdio_o = rd_byte[3'(OUT_LAST - out_cnt)];
          next_sdio_oe = 1'b1;
          next_out_cnt = out_cnt + 4'h1;
          if (out_cnt == OUT_LAST &&
              addr == WRITE_XOR_CHECKSUM_ADDR) begin
            next_checksum = CHECKSUM_RESET;
          end
        end else begin
          next_sdio_oe = 1'b0;
        end
      end
    end
  end

  // registers of the serial engine
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      state <= ST_IDLE;
      sample_rise <= 1'b0;
      bits <= 3'h0;
      shift <= 8'h00;
      addr <= 6'h00;
      checksum <= CHECKSUM_RESET;
      out_cnt <= 4'h0;
      sdio_o <= 1'b0;
      sdio_oe <= 1'b0;
      tx_cmd <= '0;
      tx_start <= 1'b0;
      tx_data <= 1'b0;
    end else begin
      state <= next_state;
      sample_rise <= next_sample_rise;
      bits <= next_bits;
      shift <= next_shift;
      addr <= next_addr;
      checksum <= next_checksum;
      out_cnt <= next_out_cnt;
      sdio_o <= next_sdio_o;
      sdio_oe <= next_sdio_oe;
      tx_cmd <= next_tx_cmd;
      tx_start <= next_tx_start;
      tx_data <= next_tx_data;
    end
  end

  // ----------------------------------------------------------------
  // two-entry write word buffer
  // ----------------------------------------------------------------
  write_word_type buf_mem [BUF_DEPTH]; // entries, 0 is head
  write_word_type next_buf [BUF_DEPTH];
  logic [1:0] buf_cnt, next_buf_cnt; // words held
  logic overrun, next_overrun; // sticky: word lost while full
  logic wr_valid, next_wr_valid; // head word present, registered
  logic pop; // receiver takes head

  assign pop = buf_cnt != 2'h0 && WR_READY_I;
  assign buf_ready = buf_cnt != 2'(BUF_DEPTH) || pop;

  // next buffer contents: shift on pop, append on push
  always_comb begin
    next_buf = buf_mem;
    next_buf_cnt = buf_cnt;
    next_overrun = overrun;
    if (pop) begin
      next_buf[0] = buf_mem[1];
      next_buf_cnt = buf_cnt - 2'h1;
    end
    if (push && buf_ready) begin
      next_buf[next_buf_cnt[0]] = '{addr: addr, data: in_byte};
      next_buf_cnt = next_buf_cnt + 2'h1;
    end else if (push) begin
      next_overrun = 1'b1;
    end
    // valid comes from a flop so the output has no logic behind it
    next_wr_valid = next_buf_cnt != 2'h0;
  end

  // buffer registers
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      buf_mem <= '{default: '0};
      buf_cnt <= 2'h0;
      overrun <= 1'b0;
      wr_valid <= 1'b0;
    end else begin
      buf_mem <= next_buf;
      buf_cnt <= next_buf_cnt;
      overrun <= next_overrun;
      wr_valid <= next_wr_valid;
    end
  end

  // ----------------------------------------------------------------
  // amplifier control
  // ----------------------------------------------------------------
  pa_state_type pa_state, next_pa_state; // amplifier phase
  logic [16:0] hold_cnt, next_hold_cnt; // hold timeout counter
  logic pa_on, next_pa_on; // amplifier enable
  localparam logic [16:0] HOLD_LAST = 17'(TIMEOUT_CYCLES - 1);

  // next amplifier state
  always_comb begin
    next_pa_state = pa_state;
    next_hold_cnt = hold_cnt;
    case (pa_state)
      PA_OFF: begin
        if (tx_start) begin
          next_pa_state = PA_ON;
        end
      end
      PA_ON: begin
        if (en_fall && tx_cmd.pa_mode) begin
          next_pa_state = PA_HOLD;
          next_hold_cnt = 17'h0;
        end else if (en_fall && tx_cmd.sync) begin
          next_pa_state = PA_WAIT_TICK;
        end else if (en_fall) begin
          next_pa_state = PA_OFF;
        end
      end
      PA_WAIT_TICK: begin
        // align switch-off to the bit clock
        if (BIT_TICK_I) begin
          next_pa_state = PA_OFF;
        end
      end
      PA_HOLD: begin
        next_hold_cnt = hold_cnt + 17'h1;
        if (hold_cnt == HOLD_LAST) begin
          next_pa_state = PA_OFF;
        end
      end
      default: begin
        next_pa_state = PA_OFF;
      end
    endcase
    next_pa_on = next_pa_state != PA_OFF;
  end

  // amplifier registers
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pa_state <= PA_OFF;
      hold_cnt <= 17'h0;
      pa_on <= 1'b0;
    end else begin
      pa_state <= next_pa_state;
      hold_cnt <= next_hold_cnt;
      pa_on <= next_pa_on;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all from flip-flops
  // ----------------------------------------------------------------
  assign SDIO_O = sdio_o;
  assign SDIO_OE_O = sdio_oe;
  assign WR_VALID_O = wr_valid;
  assign WR_ADDR_O = buf_mem[0].addr;
  assign WR_DATA_O = buf_mem[0].data;
  assign WR_OVERRUN_O = overrun;
  assign RD_ADDR_O = addr;
  assign TX_START_O = tx_start;
  assign TX_SYNC_O = tx_cmd.sync;
  assign TX_PA_MODE_O = tx_cmd.pa_mode;
  assign TX_ENCODE_O = tx_cmd.encode;
  assign TX_POWER_SET_O = tx_cmd.power_set;
  assign TX_CHANNEL_O = tx_cmd.channel;
  assign TX_DATA_O = tx_data;
  assign PA_ON_O = pa_on;
  assign SYNTH_ON_O = pa_on;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);

  sequence s_read_last;
    state == ST_READ && en_s && !en_fall && launch && out_cnt == OUT_LAST;
  endsequence

  a_select_ends_cmd: assert property (en_fall |=> state == ST_IDLE)
    else $error("command not ended by select fall");
  a_low_polarity: assert property (en_rise && !sck_s |=> !sample_rise)
    else $error("falling-edge sampling not chosen");
  a_high_polarity: assert property (en_rise && sck_s |=> sample_rise)
    else $error("rising-edge sampling not chosen");
  a_polarity_hold: assert property (!en_rise |=> $stable(sample_rise))
    else $error("edge polarity changed mid command");
  a_burst_increment: assert property (
    byte_done && state == ST_WRITE |=> addr == $past(addr) + 6'h1)
    else $error("burst address not incremented");
  a_checksum_xor: assert property (
    byte_done &&
    (state == ST_WRITE || in_byte[FUNC_HI:FUNC_LO] == FUNC_WRITE)
    |=> checksum == ($past(checksum) ^ $past(in_byte)))
    else $error("checksum not accumulated");
  a_checksum_clear: assert property (
    s_read_last ##0 addr == WRITE_XOR_CHECKSUM_ADDR |=> checksum == 8'h00)
    else $error("checksum not cleared by read");
  a_read_release: assert property (sdio_oe |-> state == ST_READ)
    else $error("data line driven outside a read");
  a_pa_drop: assert property (
    pa_state == PA_ON && en_fall && !tx_cmd.pa_mode && !tx_cmd.sync
    |=> !pa_on)
    else $error("amplifier not switched off");
  a_sync_align: assert property (
    pa_state == PA_WAIT_TICK && !BIT_TICK_I |=> pa_on)
    else $error("amplifier dropped before bit tick");
  a_hold_timeout: assert property (
    pa_state == PA_HOLD && hold_cnt == HOLD_LAST |=> !pa_on && !SYNTH_ON_O)
    else $error("hold timeout missed");

endmodule : three_wire_serial_control_port

// [pkg/serial_port_pkg.sv]
// shared constants and types of the three-wire serial control port
package serial_port_pkg;

  // ----------------------------------------------------------------
  // command byte layout
  // ----------------------------------------------------------------
  localparam int FUNC_HI = 7; // function_code_high position
  localparam int FUNC_LO = 6; // function_code_low position
  localparam int ADDR_HI = 5; // register_address_field top bit
  localparam logic [1:0] FUNC_WRITE = 2'h0; // register write
  localparam logic [1:0] FUNC_READ = 2'h1; // register read
  localparam logic [1:0] FUNC_RSVD = 2'h2; // reserved, ignored
  localparam logic [1:0] FUNC_TX = 2'h3; // transmit command

  // transmit command field positions, bit 5 down to bit 0
  localparam int TX_SYNC_BIT = 5; // data synchronisation
  localparam int TX_PAMODE_BIT = 4; // amplifier mode
  localparam int TX_ENC_BIT = 3; // encoding enable
  localparam int TX_PWR_BIT = 2; // power/modulation setting
  localparam int TX_CHAN_HI = 1; // channel select top bit

  // ----------------------------------------------------------------
  // registers and counts
  // ----------------------------------------------------------------
  localparam logic [5:0] WRITE_XOR_CHECKSUM_ADDR = 6'h00; // checksum
  localparam logic [7:0] CHECKSUM_RESET = 8'h00; // value after reset
  localparam logic [2:0] LAST_BIT = 3'h7; // eighth bit of a byte
  localparam logic [3:0] OUT_LAST = 4'h7; // last bit launched
  localparam logic [3:0] OUT_DONE = 4'h8; // read byte finished
  localparam int HOLD_TIMEOUT = 65536; // amplifier hold, clock periods
  localparam int BUF_DEPTH = 2; // write word buffer entries

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_CMD = 3'h1, ST_WRITE = 3'h3,
    ST_READ = 3'h2, ST_TX = 3'h6
  } serial_state_type;

  typedef enum logic [1:0] {
    PA_OFF = 2'h0, PA_ON = 2'h1, PA_WAIT_TICK = 2'h3, PA_HOLD = 2'h2
  } pa_state_type;

  typedef struct packed {
    logic [5:0] addr; // target register
    logic [7:0] data; // written value
  } write_word_type;

  typedef struct packed {
    logic sync; // synchronous mode
    logic pa_mode; // amplifier hold mode
    logic encode; // encoder enable
    logic power_set; // power/modulation setting
    logic [1:0] channel; // channel select
  } tx_cmd_type;

endpackage : serial_port_pkg

// [test/serial_host_model.sv]
// host model that drives select, serial clock and data line of the port
`timescale 1ns/1ns
module serial_host_model (
  input wire logic clk_i,
  input wire logic sdio_i,
  output logic en_o,
  output logic sck_o,
  output logic sdio_o,
  output logic sdio_oe_o
);
  // ------------------------------------------------------------
  // link timing
  // ------------------------------------------------------------
  localparam int HALF = 5; // half of the 80 ns link clock period
  logic idle_lvl; // clock level parked at select rise

  // everything idle and released at time zero
  initial begin
    en_o = 1'b0;
    sck_o = 1'b0;
    sdio_o = 1'b0;
    sdio_oe_o = 1'b0;
    idle_lvl = 1'b0;
  end

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  // wait a number of system clock edges
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick

  // park clock at the chosen level, then raise select
  task automatic frame_start(input logic pol);
    idle_lvl = pol;
    sck_o <= pol;
    tick(HALF);
    en_o <= 1'b1;
    tick(HALF);
  endtask : frame_start

  // one byte, msb first; data set before the sampling edge
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      sdio_oe_o <= 1'b1;
      sdio_o <= b[i];
      sck_o <= ~idle_lvl;
      tick(HALF);
      sck_o <= idle_lvl;
      tick(HALF);
    end
  endtask : send_byte

  // line released; device launches, host samples a half later
  task automatic recv_byte(output logic [7:0] b);
    sdio_oe_o <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      sck_o <= ~idle_lvl;
      tick(HALF);
      b[i] = sdio_i;
      sck_o <= idle_lvl;
      tick(HALF);
    end
  endtask : recv_byte

  // static data level with the clock standing still
  task automatic hold_level(input logic l);
    sdio_oe_o <= 1'b1;
    sdio_o <= l;
    tick(HALF);
  endtask : hold_level

  // select low ends the command
  task automatic drop_en();
    en_o <= 1'b0;
  endtask : drop_en

  // end the frame and let the pull-down take the line
  task automatic frame_end();
    drop_en();
    tick(HALF);
    sdio_oe_o <= 1'b0;
    tick(HALF);
  endtask : frame_end

  // 100 us pause so the synthesizer can lock
  task automatic settle();
    tick(12500);
  endtask : settle
endmodule : serial_host_model

// [test/three_wire_serial_control_port_tb.sv]
// self-checking bench for the three-wire serial control port
`timescale 1ns/1ns
module three_wire_serial_control_port_tb
  import serial_port_pkg::*;
;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic clock = 1'b0; // 125 MHz system clock
  logic rst_n; // async reset, active low
  logic wr_ready, pol;
  logic bit_tick = 1'b0; // bit-rate tick to the design
  wire en, sck, host_d, host_oe, sdio_o, sdio_oe, sdio_line;
  wire wr_valid, overrun, tx_start, tx_data, pa_on, synth_on;
  wire [5:0] wr_addr, rd_addr, tx_f;
  wire [7:0] wr_data, rd_data;
  logic [7:0] csum, got; // expected checksum, read result
  logic [3:0] tick_cnt = 4'h0; // bit-rate divider
  logic [7:0] bank [64]; // register bank model
  int n_mismatch, num_checks, n_starts, n_writes, s0, k;
  logic [5:0] codes [4] = '{6'h00, 6'h05, 6'h2A, 6'h3F};
  logic [7:0] burst [3] = '{8'hA5, 8'h3C, 8'h7E};

  // pull-down holds the data line low when nobody drives
  assign sdio_line = host_oe ? host_d : (sdio_oe ? sdio_o : 1'b0);
  assign rd_data = bank[rd_addr];

  // clock generator
  always #4 clock = ~clock;

  // ------------------------------------------------------------
  // design, host and register bank
  // ------------------------------------------------------------
  three_wire_serial_control_port #(.TIMEOUT_CYCLES(16))
  three_wire_serial_control_port_i (
    .CLOCK_I(clock), .RST_N_I(rst_n), .EN_I(en), .SCK_I(sck),
    .SDIO_I(sdio_line), .SDIO_O(sdio_o), .SDIO_OE_O(sdio_oe),
    .WR_VALID_O(wr_valid), .WR_ADDR_O(wr_addr), .WR_DATA_O(wr_data),
    .WR_READY_I(wr_ready), .WR_OVERRUN_O(overrun), .RD_ADDR_O(rd_addr),
    .RD_DATA_I(rd_data), .TX_START_O(tx_start), .TX_SYNC_O(tx_f[5]),
    .TX_PA_MODE_O(tx_f[4]), .TX_ENCODE_O(tx_f[3]),
    .TX_POWER_SET_O(tx_f[2]), .TX_CHANNEL_O(tx_f[1:0]),
    .TX_DATA_O(tx_data), .BIT_TICK_I(bit_tick), .PA_ON_O(pa_on),
    .SYNTH_ON_O(synth_on)
  );

  serial_host_model host_i (
    .clk_i(clock), .sdio_i(sdio_line), .en_o(en), .sck_o(sck),
    .sdio_o(host_d), .sdio_oe_o(host_oe)
  );

  // bank takes words, counts writes and start pulses, makes bit tick
  always @(posedge clock) begin
    if (wr_valid === 1'b1 && wr_ready) begin
      bank[wr_addr] <= wr_data;
      n_writes <= n_writes + 1;
    end
    if (tx_start === 1'b1) begin
      n_starts <= n_starts + 1;
    end
    tick_cnt <= tick_cnt + 4'h1;
    bit_tick <= (tick_cnt == 4'hF);
  end

  // ------------------------------------------------------------
  // compare, access and closing tasks
  // ------------------------------------------------------------
  task automatic cmp_byte(input logic [7:0] g, e, input string m);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask : cmp_byte

  task automatic cmp_bit(input logic g, e, input string m);
    cmp_byte({7'h00, g}, {7'h00, e}, m);
  endtask : cmp_bit

  task automatic test_done();
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done

  // a bounded wait ran out
  task automatic timeout(input string m);
    n_mismatch++;
    $display("CHECK FAILED %0t timeout %s", $time, m);
    test_done();
  endtask : timeout

  // single register write, checksum tracked
  task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
    host_i.frame_start(pol);
    host_i.send_byte({FUNC_WRITE, a});
    host_i.send_byte(d);
    host_i.frame_end();
    csum = csum ^ {FUNC_WRITE, a} ^ d;
  endtask : wr_reg

  // register read; line must be released afterwards
  task automatic rd_reg(input logic [5:0] a, output logic [7:0] d);
    host_i.frame_start(pol);
    host_i.send_byte({FUNC_READ, a});
    host_i.recv_byte(d);
    host_i.frame_end();
    cmp_bit(sdio_oe, 1'b0, "line released");
  endtask : rd_reg

  // amplifier and synthesizer must switch off within the bound
  task automatic wait_pa_off(input int bound);
    int j;
    for (j = 0; j < bound && pa_on !== 1'b0; j++) @(posedge clock);
    if (j == bound) timeout("amplifier stays on");
    cmp_bit(synth_on, 1'b0, "synth off");
  endtask : wait_pa_off

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    rst_n = 1'b0;
    wr_ready = 1'b1;
    pol = 1'b0;
    csum = 8'h00;
    for (int i = 0; i < 64; i++) bank[i] = 8'(i) ^ 8'hC3;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    host_i.tick(6);
    // clocking with select low
    host_i.send_byte({FUNC_WRITE, 6'h04});
    host_i.send_byte(8'hFF);
    host_i.frame_end();
    cmp_byte(8'(n_writes), 8'h00, "write with select low");
    // checksum of two writes, then clear on read
    wr_reg(6'h04, 8'h02);
    wr_reg(6'h05, 8'h01);
    rd_reg(WRITE_XOR_CHECKSUM_ADDR, got);
    cmp_byte(got, 8'h02, "checksum example");
    rd_reg(WRITE_XOR_CHECKSUM_ADDR, got);
    cmp_byte(got, 8'h00, "checksum cleared");
    // burst with the other clock polarity
    csum = 8'h00;
    pol = 1'b1;
    host_i.frame_start(pol);
    host_i.send_byte({FUNC_WRITE, 6'h06});
    csum = csum ^ {FUNC_WRITE, 6'h06};
    foreach (burst[i]) begin
      host_i.send_byte(burst[i]);
      csum = csum ^ burst[i];
    end
    host_i.frame_end();
    foreach (burst[i]) begin
      rd_reg(6'h06 + 6'(i), got);
      cmp_byte(got, burst[i], "burst readback");
    end
    pol = 1'b0;
    rd_reg(WRITE_XOR_CHECKSUM_ADDR, got);
    cmp_byte(got, csum, "burst checksum");
    // reserved function code writes nothing
    host_i.frame_start(pol);
    host_i.send_byte({FUNC_RSVD, 6'h04});
    host_i.send_byte(8'h77);
    host_i.frame_end();
    rd_reg(6'h04, got);
    cmp_byte(got, 8'h02, "reserved code wrote");
    rd_reg(WRITE_XOR_CHECKSUM_ADDR, got);
    cmp_byte(got, 8'h00, "reserved code summed");
    // transmit commands over every channel and mode
    for (int i = 0; i < 4; i++) begin
      s0 = n_starts;
      pol = i[0];
      host_i.frame_start(pol);
      host_i.send_byte({FUNC_TX, codes[i]});
      host_i.tick(4);
      cmp_byte(8'(n_starts - s0), 8'h01, "start pulse");
      cmp_byte({2'h0, tx_f}, {2'h0, codes[i]}, "fields");
      cmp_bit(pa_on & synth_on, 1'b1, "amplifier on");
      host_i.settle();
      host_i.send_byte(8'hB4 ^ {2'h0, codes[i]});
      cmp_bit(tx_data, codes[i][0], "datagram bit");
      host_i.hold_level(~codes[i][0]);
      host_i.drop_en();
      if (codes[i][4]) begin
        host_i.tick(10);
        cmp_bit(pa_on, 1'b1, "amplifier held");
        cmp_bit(tx_data, ~codes[i][0], "level latched");
        wait_pa_off(40);
      end else begin
        wait_pa_off(codes[i][5] ? 40 : 8);
      end
      host_i.frame_end();
    end
    // stalled bank: two words kept, third lost
    wr_ready <= 1'b0;
    host_i.frame_start(pol);
    host_i.send_byte({FUNC_WRITE, 6'h10});
    host_i.send_byte(8'h11);
    host_i.send_byte(8'h22);
    cmp_bit(wr_valid, 1'b1, "word waiting");
    cmp_byte({2'h0, wr_addr}, 8'h10, "head address");
    cmp_byte(wr_data, 8'h11, "head data");
    cmp_bit(overrun, 1'b0, "two words fit");
    host_i.send_byte(8'h33);
    host_i.frame_end();
    cmp_bit(overrun, 1'b1, "third word lost");
    wr_ready <= 1'b1;
    for (k = 0; k < 50 && wr_valid !== 1'b0; k++) @(posedge clock);
    if (k == 50) timeout("buffer not drained");
    rd_reg(6'h11, got);
    cmp_byte(got, 8'h22, "second word");
    rd_reg(6'h12, got);
    cmp_byte(got, 8'h12 ^ 8'hC3, "lost word written");
    // reset in mid-run
    rst_n <= 1'b0;
    host_i.tick(2);
    cmp_bit(overrun | sdio_oe | pa_on | wr_valid, 1'b0, "reset outputs");
    rst_n <= 1'b1;
    host_i.tick(6);
    rd_reg(WRITE_XOR_CHECKSUM_ADDR, got);
    cmp_byte(got, CHECKSUM_RESET, "checksum after reset");
    test_done();
  end
endmodule : three_wire_serial_control_port_tb
